/* ccm_event_irq_status_regs.sv */
// Wishbone register slice for the packet cipher events, shortcut, enables and check result.
`timescale 1ns/1ps
module ccm_event_irq_status_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Task pulses towards the cipher core.
    output logic keystream_start_task_o,
    output logic cipher_run_task_o,
    output logic cipher_stop_task_o,
    // Event pulses and check outcome from the cipher core.
    input wire logic keystream_done_event_i,
    input wire logic cipher_done_event_i,
    input wire logic error_event_i,
    input wire logic integrity_valid_i,
    input wire logic integrity_pass_i,
    // Interrupt request.
    output logic irq_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------

    // The decoder needs every offset up to the result register.
    if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 11 and 32");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // True when the bus address selects the word at the given offset.
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
        logic [ADDR_W-1:0] full;
        full = ADDR_W'(off);
        hit = (addr[ADDR_W-1:2] == full[ADDR_W-1:2]);
    endfunction

    // Places a single bit at the given position of a zeroed word.
    function automatic logic [31:0] word_bit(input logic val, input int pos);
        logic [31:0] w;
        w = 32'h00000000;
        w[pos] = val;
        word_bit = w;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic ks_start;
        logic run;
        logic stop;
        logic chain;
        logic integrity;
        logic irq;
    } regs_state_t;

    regs_state_t state_q;
    regs_state_t state_d;

    // Event flags and enables kept in the leaf modules.
    logic ks_flag;
    logic done_flag;
    logic err_flag;
    logic [ccm_regs_pkg::NUM_EVENTS-1:0] irq_en;
    logic [ccm_regs_pkg::NUM_EVENTS-1:0] pending;

    // ------------------------------------------------------------
    // Bus access qualifiers
    // ------------------------------------------------------------

    // A cycle is live while the master holds cyc and stb together.
    logic req;
    // The write lands on the edge where the master sees ack.
    logic wr_now;
    // Only the low byte carries defined fields.
    logic low_lane;
    logic [31:0] wdata;

    assign req = cyc_i & stb_i;
    assign low_lane = sel_i[0];
    assign wr_now = req & we_i & state_q.ack & low_lane;
    assign wdata = dat_i;

    // ------------------------------------------------------------
    // Write strobes per register
    // ------------------------------------------------------------

    logic wr_ks_task;
    logic wr_run_task;
    logic wr_stop_task;
    logic wr_ks_flag;
    logic wr_done_flag;
    logic wr_err_flag;
    logic wr_shortcut;
    logic wr_en_set;
    logic wr_en_clr;

    // Address decoding of the write strobes.
    always_comb begin
        wr_ks_task = 1'b0;
        wr_run_task = 1'b0;
        wr_stop_task = 1'b0;
        wr_ks_flag = 1'b0;
        wr_done_flag = 1'b0;
        wr_err_flag = 1'b0;
        wr_shortcut = 1'b0;
        wr_en_set = 1'b0;
        wr_en_clr = 1'b0;
        if (!wr_now) begin
            wr_ks_task = 1'b0;
        end else if (hit(adr_i, ccm_regs_pkg::KS_START_TASK_OFF)) begin
            wr_ks_task = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::CIPHER_RUN_TASK_OFF)) begin
            wr_run_task = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::CIPHER_STOP_TASK_OFF)) begin
            wr_stop_task = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::KS_DONE_EVENT_OFF)) begin
            wr_ks_flag = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::CIPHER_DONE_EVENT_OFF)) begin
            wr_done_flag = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::ERROR_EVENT_OFF)) begin
            wr_err_flag = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::SHORTCUT_CONTROL_OFF)) begin
            wr_shortcut = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::IRQ_ENABLE_SET_OFF)) begin
            wr_en_set = 1'b1;
        end else if (hit(adr_i, ccm_regs_pkg::IRQ_ENABLE_CLEAR_OFF)) begin
            wr_en_clr = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------

    event_flag u_ks_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hw_set_i(keystream_done_event_i),
        .sw_wr_i(wr_ks_flag),
        .sw_val_i(wdata[ccm_regs_pkg::FLAG_BIT]),
        .flag_o(ks_flag)
    );

    event_flag u_done_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hw_set_i(cipher_done_event_i),
        .sw_wr_i(wr_done_flag),
        .sw_val_i(wdata[ccm_regs_pkg::FLAG_BIT]),
        .flag_o(done_flag)
    );

    // The error flag is set by error_event_i and feeds the interrupt through its enable bit.
    event_flag u_err_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hw_set_i(error_event_i),
        .sw_wr_i(wr_err_flag),
        .sw_val_i(wdata[ccm_regs_pkg::FLAG_BIT]),
        .flag_o(err_flag)
    );

    // ------------------------------------------------------------
    // Interrupt enables
    // ------------------------------------------------------------

    enable_mask #(
        .W(ccm_regs_pkg::NUM_EVENTS)
    ) u_enables (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_wr_i(wr_en_set),
        .clr_wr_i(wr_en_clr),
        .bits_i(wdata[ccm_regs_pkg::NUM_EVENTS-1:0]),
        .en_o(irq_en)
    );

    // Flags in the same order as their enable bits.
    always_comb begin
        pending = '0;
        pending[ccm_regs_pkg::IRQ_KS_DONE_BIT] = ks_flag;
        pending[ccm_regs_pkg::IRQ_CIPHER_DONE_BIT] = done_flag;
        pending[ccm_regs_pkg::IRQ_ERROR_BIT] = err_flag;
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------

    logic [31:0] rd_word;

    // Tasks read as zero; unmapped words read as zero too.
    always_comb begin
        rd_word = ccm_regs_pkg::UNMAPPED_READ;
        if (hit(adr_i, ccm_regs_pkg::KS_DONE_EVENT_OFF)) begin
            rd_word = word_bit(ks_flag, ccm_regs_pkg::FLAG_BIT);
        end else if (hit(adr_i, ccm_regs_pkg::CIPHER_DONE_EVENT_OFF)) begin
            rd_word = word_bit(done_flag, ccm_regs_pkg::FLAG_BIT);
        end else if (hit(adr_i, ccm_regs_pkg::ERROR_EVENT_OFF)) begin
            rd_word = word_bit(err_flag, ccm_regs_pkg::FLAG_BIT);
        end else if (hit(adr_i, ccm_regs_pkg::SHORTCUT_CONTROL_OFF)) begin
            rd_word = word_bit(state_q.chain, ccm_regs_pkg::CHAIN_BIT);
        end else if (hit(adr_i, ccm_regs_pkg::IRQ_ENABLE_SET_OFF)) begin
            rd_word = {29'h0, irq_en};
        end else if (hit(adr_i, ccm_regs_pkg::IRQ_ENABLE_CLEAR_OFF)) begin
            rd_word = {29'h0, irq_en};
        end else if (hit(adr_i, ccm_regs_pkg::INTEGRITY_RESULT_OFF)) begin
            rd_word = word_bit(state_q.integrity, ccm_regs_pkg::INTEGRITY_PASS_BIT);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Bus answer, task pulses, shortcut, check result and interrupt.
    always_comb begin
        state_d = state_q;

        // Ack rises one cycle after the request and falls right after.
        state_d.ack = req & ~state_q.ack;
        if (req & ~state_q.ack & ~we_i) begin
            state_d.rdata = rd_word;
        end else begin
            state_d.rdata = 32'h00000000;
        end

        // Task pulses last one cycle each.
        state_d.ks_start = wr_ks_task & wdata[ccm_regs_pkg::TRIGGER_BIT];
        state_d.stop = wr_stop_task & wdata[ccm_regs_pkg::TRIGGER_BIT];

        state_d.run = wr_run_task & wdata[ccm_regs_pkg::TRIGGER_BIT];

        if (keystream_done_event_i & state_q.chain) begin
            state_d.run = 1'b1;
        end

        if (wr_shortcut) begin
            state_d.chain = wdata[ccm_regs_pkg::CHAIN_BIT];
        end

        if (integrity_valid_i) begin
            state_d.integrity = integrity_pass_i;
        end

        state_d.irq = |(pending & irq_en);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Synchronous reset brings every field to its documented value.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q.ack <= 1'b0;
            state_q.rdata <= 32'h00000000;
            state_q.ks_start <= 1'b0;
            state_q.run <= 1'b0;
            state_q.stop <= 1'b0;
            state_q.chain <= ccm_regs_pkg::SHORTCUT_RESET;
            state_q.integrity <= ccm_regs_pkg::INTEGRITY_RESET;
            state_q.irq <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Every output is a field of the state register.
    assign ack_o = state_q.ack;
    assign dat_o = state_q.rdata;
    assign keystream_start_task_o = state_q.ks_start;
    assign cipher_run_task_o = state_q.run;
    assign cipher_stop_task_o = state_q.stop;
    assign irq_o = state_q.irq;

endmodule

/* ccm_regs_pkg.sv */
// Shared offsets, field positions and reset values of the cipher control register slice.
package ccm_regs_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] KS_START_TASK_OFF = 12'h000;
    localparam logic [11:0] CIPHER_RUN_TASK_OFF = 12'h004;
    localparam logic [11:0] CIPHER_STOP_TASK_OFF = 12'h008;
    localparam logic [11:0] KS_DONE_EVENT_OFF = 12'h100;
    localparam logic [11:0] CIPHER_DONE_EVENT_OFF = 12'h104;
    localparam logic [11:0] ERROR_EVENT_OFF = 12'h108;
    localparam logic [11:0] SHORTCUT_CONTROL_OFF = 12'h200;
    localparam logic [11:0] IRQ_ENABLE_SET_OFF = 12'h304;
    localparam logic [11:0] IRQ_ENABLE_CLEAR_OFF = 12'h308;
    localparam logic [11:0] INTEGRITY_RESULT_OFF = 12'h400;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TRIGGER_BIT = 0;
    localparam int FLAG_BIT = 0;
    localparam int CHAIN_BIT = 0;
    localparam int IRQ_KS_DONE_BIT = 0;
    localparam int IRQ_CIPHER_DONE_BIT = 1;
    localparam int IRQ_ERROR_BIT = 2;
    localparam int INTEGRITY_PASS_BIT = 0;
    localparam int NUM_EVENTS = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic SHORTCUT_RESET = 1'h0;
    localparam logic [NUM_EVENTS-1:0] IRQ_ENABLE_RESET = 3'h0;
    localparam logic EVENT_RESET = 1'h0;
    localparam logic INTEGRITY_RESET = 1'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

endpackage

/* event_flag.sv */
// Sticky event flag that hardware sets and software rewrites.
`timescale 1ns/1ps
module event_flag (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Hardware event and software write.
    input wire logic hw_set_i,
    input wire logic sw_wr_i,
    input wire logic sw_val_i,
    // Flag state.
    output logic flag_o
);

    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t state_q;
    flag_state_t state_d;

    // A hardware event wins over a software write in the same cycle.
    always_comb begin
        state_d = state_q;
        if (hw_set_i) begin
            state_d.flag = 1'b1;
        end else if (sw_wr_i) begin
            state_d.flag = sw_val_i;
        end
    end

    // Registers the flag.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q.flag <= ccm_regs_pkg::EVENT_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign flag_o = state_q.flag;

endmodule

/* enable_mask.sv */
// Set/clear pair of interrupt enable bits sharing one stored mask.
`timescale 1ns/1ps
module enable_mask #(
    parameter int W = 3
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Software write strobes and data.
    input wire logic set_wr_i,
    input wire logic clr_wr_i,
    input wire logic [W-1:0] bits_i,
    // Stored enables.
    output logic [W-1:0] en_o
);

    // The mask must hold at least one bit and fit in a bus word.
    if (W < 1 || W > 32) begin : g_bad_w
        $error("W must lie between 1 and 32");
    end

    typedef struct packed {
        logic [W-1:0] en;
    } mask_state_t;

    mask_state_t state_q;
    mask_state_t state_d;

    // Ones written to the set port enable, ones to the clear port disable.
    always_comb begin
        state_d = state_q;
        if (set_wr_i) begin
            state_d.en = state_q.en | bits_i;
        end
        if (clr_wr_i) begin
            state_d.en = state_q.en & ~bits_i;
        end
    end

    // Registers the mask.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q.en <= W'(ccm_regs_pkg::IRQ_ENABLE_RESET);
        end else begin
            state_q <= state_d;
        end
    end

    assign en_o = state_q.en;

endmodule

/* ccm_event_irq_status_regs_props.sv */
// Concurrent checks on the ports of the cipher control register slice.
`timescale 1ns/1ps
module ccm_event_irq_status_regs_props #(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Core side.
    input wire logic cipher_run_task_o,
    input wire logic keystream_done_event_i,
    input wire logic cipher_done_event_i,
    input wire logic error_event_i,
    input wire logic integrity_valid_i,
    input wire logic integrity_pass_i,
    input wire logic irq_o
);
    // Shadow of the shortcut, the enables and the check result.
    typedef struct packed {
        logic sc;
        logic [2:0] en;
        logic res;
    } shadow_t;
    shadow_t s_q;
    shadow_t s_d;
    logic land;
    logic run_wr;
    logic en_rd;
    logic [9:0] wa;

    // Shadow follows every write that lands at an ack edge.
    always_comb begin
        wa = 10'(adr_i >> 2);
        land = ack_o && cyc_i && stb_i && we_i && sel_i[0];
        run_wr = land && (wa == 10'h001) && dat_i[0];
        en_rd = ack_o && cyc_i && !we_i && (wa == 10'h0C1 || wa == 10'h0C2);
        s_d = s_q;
        if (land && wa == 10'h080) s_d.sc = dat_i[0];
        if (land && wa == 10'h0C1) s_d.en = s_q.en | dat_i[2:0];
        if (land && wa == 10'h0C2) s_d.en = s_q.en & ~dat_i[2:0];
        if (integrity_valid_i) s_d.res = integrity_pass_i;
    end

    // Shadow register.
    always_ff @(posedge clk_i) begin
        s_q <= rst_i ? '0 : s_d;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence

    ack_reply_a: assert property (req_s |=> ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h00000000)
        else $error("read data outside ack");
    chain_on_a: assert property (keystream_done_event_i && s_q.sc |=> cipher_run_task_o)
        else $error("chained run task missing");
    chain_off_a: assert property (!(keystream_done_event_i && s_q.sc) && !run_wr
        |=> !cipher_run_task_o) else $error("run task without cause");
    ks_irq_a: assert property (keystream_done_event_i && s_q.en[0] && !ack_o
        |-> ##2 irq_o) else $error("keystream interrupt missing");
    done_irq_a: assert property (cipher_done_event_i && s_q.en[1] && !ack_o
        |-> ##2 irq_o) else $error("cipher done interrupt missing");
    err_irq_a: assert property (error_event_i && s_q.en[2] && !ack_o
        |-> ##2 irq_o) else $error("error interrupt missing");
    irq_cause_a: assert property (irq_o |-> $past(s_q.en) != 3'h0)
        else $error("interrupt with no enable");
    en_read_a: assert property (en_rd
        |-> dat_o == {29'h0, s_q.en}) else $error("enable readback wrong");
    result_read_a: assert property (ack_o && cyc_i && !we_i && wa == 10'h100
        && !$past(integrity_valid_i) |-> dat_o == {31'h0, s_q.res}) else $error("result wrong");
endmodule

bind ccm_event_irq_status_regs ccm_event_irq_status_regs_props #(.ADDR_W(ADDR_W)) props_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cipher_run_task_o(cipher_run_task_o), .keystream_done_event_i(keystream_done_event_i),
    .cipher_done_event_i(cipher_done_event_i), .error_event_i(error_event_i),
    .integrity_valid_i(integrity_valid_i), .integrity_pass_i(integrity_pass_i), .irq_o(irq_o));

/* ccm_event_irq_status_regs_tb.sv */
// Self-checking bench for the cipher control register slice.
`timescale 1ns/1ps
module ccm_event_irq_status_regs_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic run_o;
    logic ks_o;
    logic stop_o;
    logic irq_o;
    logic [2:0] ev_i = 3'h0;
    logic valid_i = 1'b0;
    logic pass_i = 1'b0;
    int failures = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h4D044F54;
    logic [31:0] rd;
    logic [2:0] en_m;
    logic [11:0] offs [9] = '{12'h100, 12'h104, 12'h108, 12'h200, 12'h304, 12'h308,
        12'h400, 12'h000, 12'h0F0};

    ccm_event_irq_status_regs ccm_event_irq_status_regs_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .keystream_start_task_o(ks_o), .cipher_run_task_o(run_o), .cipher_stop_task_o(stop_o),
        .keystream_done_event_i(ev_i[0]), .cipher_done_event_i(ev_i[1]),
        .error_event_i(ev_i[2]), .integrity_valid_i(valid_i), .integrity_pass_i(pass_i),
        .irq_o(irq_o));

    // Clock of 40 ns period.
    always #20 clk_i = ~clk_i;

    // Next random value.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    // Enable mask expected after a set or a clear write of d.
    function automatic logic [2:0] exp_en(input logic [2:0] m, input logic set,
        input logic [2:0] d);
        return set ? (m | d) : (m & ~d);
    endfunction

    // Compares of words and of single bits.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // One classic bus cycle; read data lands in rd.
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        // Ack and read data are taken at the rising edge that samples ack high.
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        chk_bit(ack_o, 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // One-cycle pulse on event k, seen by the core at the edge the task ends on.
    task automatic ev(input int k);
        @(posedge clk_i);
        ev_i[k] <= 1'b1;
        @(posedge clk_i);
        ev_i <= 3'h0;
    endtask

    task automatic settle2();
        @(negedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Watchdog for a hung bus or handshake.
    initial begin
        #(40 * 20000);
        failures++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and the unmapped hole read zero; stray write ignored.
        wb(1'b1, 12'h0F0, 32'hFFFFFFFF, 4'hF);
        foreach (offs[i]) begin
            wb(1'b0, offs[i], 32'h0, 4'hF);
            chk_word(rd, 32'h0);
        end
        $display("test reset done");
        // Random set and clear writes, some with byte 0 not selected.
        en_m = 3'h0;
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            wb(1'b1, seed[3] ? 12'h304 : 12'h308, seed, seed[4] ? 4'hF : 4'hE);
            if (seed[4]) en_m = exp_en(en_m, seed[3], seed[2:0]);
            wb(1'b0, 12'h304, 32'h0, 4'hF);
            chk_word(rd, {29'h0, en_m});
            wb(1'b0, 12'h308, 32'h0, 4'hF);
            chk_word(rd, {29'h0, en_m});
        end
        $display("test enables done");
        // Each event sets its flag and raises the interrupt one cycle late.
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, 12'h304, 32'h7, 4'hF);
            ev(k);
            @(negedge clk_i);
            chk_bit(irq_o, 1'b0);
            @(negedge clk_i);
            chk_bit(irq_o, 1'b1);
            wb(1'b0, 12'h100 + 12'(4 * k), 32'h0, 4'hF);
            chk_word(rd, 32'h1);
            wb(1'b1, 12'h308, 32'h1 << k, 4'hF);
            settle2();
            chk_bit(irq_o, 1'b0);
            wb(1'b1, 12'h304, 32'h1 << k, 4'hF);
            settle2();
            chk_bit(irq_o, 1'b1);
            wb(1'b1, 12'h100 + 12'(4 * k), 32'h0, 4'hF);
            settle2();
            chk_bit(irq_o, 1'b0);
        end
        $display("test events done");
        // Shortcut on and off, then a direct run task write.
        wb(1'b1, 12'h200, 32'h1, 4'hF);
        ev(0);
        @(negedge clk_i);
        chk_bit(run_o, 1'b1);
        @(negedge clk_i);
        chk_bit(run_o, 1'b0);
        wb(1'b1, 12'h200, 32'h0, 4'hF);
        ev(0);
        @(negedge clk_i);
        chk_bit(run_o, 1'b0);
        wb(1'b1, 12'h004, 32'h1, 4'hF);
        @(negedge clk_i);
        chk_bit(run_o, 1'b1);
        @(negedge clk_i);
        chk_bit(run_o, 1'b0);
        wb(1'b1, 12'h004, 32'h0, 4'hF);
        @(negedge clk_i);
        chk_bit(run_o, 1'b0);
        // The other two task registers pulse their own outputs only.
        wb(1'b1, 12'h000, 32'h1, 4'hF);
        @(negedge clk_i);
        chk_bit(ks_o, 1'b1);
        chk_bit(stop_o, 1'b0);
        wb(1'b1, 12'h008, 32'h1, 4'hF);
        @(negedge clk_i);
        chk_bit(stop_o, 1'b1);
        chk_bit(ks_o, 1'b0);
        wb(1'b1, 12'h100, 32'h0, 4'hF);
        $display("test shortcut done");
        // Random check outcomes, each read back after its pulse.
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            @(posedge clk_i);
            valid_i <= 1'b1;
            pass_i <= seed[0];
            @(posedge clk_i);
            valid_i <= 1'b0;
            pass_i <= ~seed[0];
            wb(1'b0, 12'h400, 32'h0, 4'hF);
            chk_word(rd, {31'h0, seed[0]});
        end
        $display("test result done");
        // A reset in mid-run brings shortcut, enables and result back to zero.
        wb(1'b1, 12'h200, 32'h1, 4'hF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (offs[i]) begin
            wb(1'b0, offs[i], 32'h0, 4'hF);
            chk_word(rd, 32'h0);
        end
        $display("test mid reset done");
        print_verdict();
    end
endmodule
